/* File: common/rlsd_regs.svh */
/*
 * register indices, field positions, reset values and timing counts of the
 * resistor lcd segment driver.
 * assumes: included by bare name; byte address of a register is four times its index.
 */
`ifndef RLSD_REGS_SVH
`define RLSD_REGS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------------
`define RLSD_IDX_PORT1_SEG 10'h09c
`define RLSD_IDX_PORT2_SEG 10'h09d
`define RLSD_IDX_PORT3_COM 10'h09e
`define RLSD_IDX_DIV_HIGH 10'h0aa
`define RLSD_IDX_DISP_CTL 10'h0ab
`define RLSD_IDX_DIV_LOW 10'h0ac
`define RLSD_IDX_DRIVE_CTL 10'h0ad
`define RLSD_IDX_STATUS 10'h0af
`define RLSD_IDX_PORT0_SEG 10'h0b6
`define RLSD_IDX_RAM_FIRST 10'h1e0
`define RLSD_IDX_RAM_LAST 10'h1f2

// ----------------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------------
`define RLSD_CTL_PANEL_SEL 7
`define RLSD_CTL_DRIVER_ON 6
`define RLSD_CTL_CONTRAST_EN 5
`define RLSD_CTL_DUTY 4
`define RLSD_DRV_RSUM 4
`define RLSD_MASK_DRIVE 8'h1f
`define RLSD_MASK_DIV_HIGH 8'h01
`define RLSD_MASK_PORT0 8'h07
`define RLSD_REG_RESET 8'h00

// ----------------------------------------------------------------------------
// encodings
// ----------------------------------------------------------------------------
`define RLSD_OSC_LF_A 4'ha
`define RLSD_OSC_LF_B 4'hd
`define RLSD_OSC_MF_A 4'h3
`define RLSD_OSC_MF_B 4'h6
`define RLSD_OSC_RC 4'h0
`define RLSD_OSC_XTAL 4'he
`define RLSD_MODE_HIGH_SUM 2'h0
`define RLSD_MODE_LOW_SUM 2'h1
`define RLSD_MODE_FAST 2'h2
`define RLSD_CONTRAST_FULL 4'hf
`define RLSD_CONTRAST_ALIAS 4'he
`define RLSD_RESP_OKAY 2'h0
`define RLSD_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
`define RLSD_FRAME_TICKS 512
`define RLSD_COM_PERIOD_4 9'h080
`define RLSD_COM_PERIOD_8 9'h040
`define RLSD_DIV_LF 9'h001
`define RLSD_DIV_MF 9'h004

`endif

/* File: common/rlsd_pkg.sv */
/*
 * types of the resistor lcd segment driver.
 * assumes: nothing beyond the register header.
 */
package rlsd_pkg;

  typedef enum logic [2:0] {
    RLSD_BUS_IDLE = 3'b001,
    RLSD_BUS_WRESP = 3'b010,
    RLSD_BUS_RRESP = 3'b100
  } rlsd_bus_t;

  typedef struct packed {
    rlsd_bus_t bus;
    logic aw_have;
    logic w_have;
    logic [9:0] widx;
    logic [7:0] wdata;
    logic wlane;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [7:0] port0_seg;
    logic [7:0] port1_seg;
    logic [7:0] port2_seg;
    logic [7:0] port3_com;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [7:0] disp_ctl;
    logic [7:0] drive_ctl;
    logic [18:0][7:0] ram;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [8:0] div_cnt;
    logic [8:0] phase;
    logic [7:0] com_drive;
    logic [18:0] seg_drive;
    logic [7:0] com_pin_en;
    logic [18:0] seg_pin_en;
    logic low_bias_sel;
    logic bias_sum_900k;
    logic quarter_bias;
    logic [3:0] panel_supply_level;
    logic frame_start;
    logic display_active;
  } rlsd_state_t;

endpackage : rlsd_pkg

/* File: hw/rlsd_driver.sv */
/*
 * resistor lcd segment driver: axi4-lite register file, display ram,
 * frame clock derivation, common/segment scan and bias control.
 * assumes: source clock ticks arrive as asynchronous square waves on pins;
 * oscillator_option and power_down are steady levels from logic on aclk.
 */
`timescale 1ns/10ps
`include "rlsd_regs.svh"

// Summary of operation
// - display ram 1E0-1F2 always cpu accessible
// - panel select bit set disables lcd
// - contrast enable picks level, else full supply
// - power-down blanks unless a 32k or 128k option is selected
// - reset blanks display, outputs low except supply level full
// - option 1010/1101: 32k source, 64 hz
// - option 0011/0110: 128k source, fixed frame
// - option 0000 rc, 1110 crystal, divided
// - one frame per 512 driver clocks
// - nine-bit divider, zero passes through
// - duty bit: four or eight commons
// - driver on bit enables lcd
// - sixteen contrast codes, 1110 equals 1111
// - drive scheme picks bias network
// - fast charge: low resistors while refreshing
// - fast charge time fraction of common
// - resistor sum bit: 225k or 900k
// - port0 bits hand pins to seg17-19
// - port1 bits hand pins to seg1-8
// - port2 bits hand pins to seg9-16
// - port3 bits hand pins to commons
// - ram byte per segment, bit per common
module rlsd_driver #(
  parameter int SEG_COUNT = 19, // segment lines
  parameter int COM_COUNT = 8 // common lines
) (
  input wire logic aclk, // system clock, 40 mhz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [3:0] oscillator_option, // clock source code option
  input wire logic power_down, // chip in power-down
  input wire logic lf_clk_pin, // 32.768 khz source
  input wire logic mf_clk_pin, // 128 khz source
  input wire logic rc_clk_pin, // internal rc source
  input wire logic xtal_clk_pin, // crystal or ceramic source
  output logic [7:0] com_drive, // common select levels
  output logic [18:0] seg_drive, // segment select levels
  output logic [7:0] com_pin_en, // pins given to commons
  output logic [18:0] seg_pin_en, // pins given to segments
  output logic low_bias_sel, // low resistance network chosen
  output logic bias_sum_900k, // high sum is 900k, else 225k
  output logic quarter_bias, // quarter bias, else third bias
  output logic [3:0] panel_supply_level, // contrast code applied
  output logic frame_start, // one-cycle pulse per frame
  output logic display_active // scan running
);

  rlsd_pkg::rlsd_state_t st;
  rlsd_pkg::rlsd_state_t next_st;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = addr[11:2];
  endfunction : reg_index

  function automatic logic is_ram(input logic [9:0] idx);
    is_ram = (idx >= `RLSD_IDX_RAM_FIRST) && (idx <= `RLSD_IDX_RAM_LAST);
  endfunction : is_ram

  function automatic logic [4:0] ram_slot(input logic [9:0] idx);
    logic [9:0] off;
    off = idx - `RLSD_IDX_RAM_FIRST;
    ram_slot = off[4:0];
  endfunction : ram_slot

  // driver clock divisor per oscillator option, 0 treated as 1
  function automatic logic [8:0] eff_div(input logic [3:0] opt, input logic [8:0] prog);
    case (opt)
      `RLSD_OSC_LF_A, `RLSD_OSC_LF_B: eff_div = `RLSD_DIV_LF;
      `RLSD_OSC_MF_A, `RLSD_OSC_MF_B: eff_div = `RLSD_DIV_MF;
      default: eff_div = (prog == 9'h000) ? 9'h001 : prog;
    endcase
  endfunction : eff_div

  function automatic logic [2:0] com_of(input logic [8:0] ph, input logic eight);
    com_of = eight ? ph[8:6] : {1'b0, ph[8:7]};
  endfunction : com_of

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  logic take_aw;
  logic take_w;
  logic take_ar;
  logic have_aw;
  logic have_w;
  logic [9:0] ridx;
  logic [7:0] rbyte;
  logic rhit;
  logic [3:0] src_edge;
  logic src_tick;
  logic lf_option;
  logic running;
  logic drv_tick;
  logic [8:0] divisor;
  logic eight_com;
  logic [2:0] com_idx;
  logic [8:0] com_pos;
  logic [8:0] charge_len;
  logic [1:0] scheme;
  logic [3:0] level;

  always_comb begin
    next_st = st;
    next_st.frame_start = 1'b0;

    // pin clocks: two flops, then edge of the second
    next_st.sync1 = {xtal_clk_pin, rc_clk_pin, mf_clk_pin, lf_clk_pin};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    src_edge = st.sync2 & ~st.sync3;

    // bus handshakes
    take_aw = awvalid && st.awready;
    take_w = wvalid && st.wready;
    take_ar = arvalid && st.arready;
    have_aw = st.aw_have || take_aw;
    have_w = st.w_have || take_w;
    if (take_aw) begin
      next_st.aw_have = 1'b1;
      next_st.widx = reg_index(awaddr);
    end
    if (take_w) begin
      next_st.w_have = 1'b1;
      next_st.wdata = wdata[7:0];
      next_st.wlane = wstrb[0];
    end

    // read decode
    ridx = reg_index(araddr);
    rhit = 1'b1;
    rbyte = 8'h00;
    if (is_ram(ridx)) begin
      rbyte = st.ram[ram_slot(ridx)];
    end else begin
      case (ridx)
        `RLSD_IDX_PORT0_SEG: rbyte = st.port0_seg;
        `RLSD_IDX_PORT1_SEG: rbyte = st.port1_seg;
        `RLSD_IDX_PORT2_SEG: rbyte = st.port2_seg;
        `RLSD_IDX_PORT3_COM: rbyte = st.port3_com;
        `RLSD_IDX_DIV_HIGH: rbyte = st.div_high;
        `RLSD_IDX_DIV_LOW: rbyte = st.div_low;
        `RLSD_IDX_DISP_CTL: rbyte = st.disp_ctl;
        `RLSD_IDX_DRIVE_CTL: rbyte = st.drive_ctl;
        `RLSD_IDX_STATUS: rbyte = {4'h0, com_of(st.phase, st.disp_ctl[`RLSD_CTL_DUTY]),
            st.display_active};
        default: rhit = 1'b0;
      endcase
    end

    case (st.bus)
      rlsd_pkg::RLSD_BUS_IDLE: begin
        if (take_ar) begin
          next_st.rvalid = 1'b1;
          next_st.rdata = {24'h000000, rbyte};
          next_st.rresp = rhit ? `RLSD_RESP_OKAY : `RLSD_RESP_SLVERR;
          next_st.bus = rlsd_pkg::RLSD_BUS_RRESP;
        end else if (have_aw && have_w) begin
          next_st.aw_have = 1'b0;
          next_st.w_have = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.bresp = `RLSD_RESP_OKAY;
          next_st.bus = rlsd_pkg::RLSD_BUS_WRESP;
          if (is_ram(next_st.widx)) begin
            if (next_st.wlane) begin
              next_st.ram[ram_slot(next_st.widx)] = next_st.wdata;
            end
          end else if (next_st.wlane) begin
            case (next_st.widx)
              `RLSD_IDX_PORT0_SEG: next_st.port0_seg = next_st.wdata & `RLSD_MASK_PORT0;
              `RLSD_IDX_PORT1_SEG: next_st.port1_seg = next_st.wdata;
              `RLSD_IDX_PORT2_SEG: next_st.port2_seg = next_st.wdata;
              `RLSD_IDX_PORT3_COM: next_st.port3_com = next_st.wdata;
              `RLSD_IDX_DIV_HIGH: next_st.div_high = next_st.wdata & `RLSD_MASK_DIV_HIGH;
              `RLSD_IDX_DIV_LOW: next_st.div_low = next_st.wdata;
              `RLSD_IDX_DISP_CTL: next_st.disp_ctl = next_st.wdata;
              `RLSD_IDX_DRIVE_CTL: next_st.drive_ctl = next_st.wdata & `RLSD_MASK_DRIVE;
              `RLSD_IDX_STATUS: next_st.bresp = `RLSD_RESP_OKAY;
              default: next_st.bresp = `RLSD_RESP_SLVERR;
            endcase
          end else if (!(next_st.widx inside {`RLSD_IDX_PORT0_SEG, `RLSD_IDX_PORT1_SEG,
              `RLSD_IDX_PORT2_SEG, `RLSD_IDX_PORT3_COM, `RLSD_IDX_DIV_HIGH, `RLSD_IDX_DIV_LOW,
              `RLSD_IDX_DISP_CTL, `RLSD_IDX_DRIVE_CTL, `RLSD_IDX_STATUS})) begin
            next_st.bresp = `RLSD_RESP_SLVERR;
          end
        end
      end
      rlsd_pkg::RLSD_BUS_WRESP: begin
        if (bready) begin
          next_st.bvalid = 1'b0;
          next_st.bus = rlsd_pkg::RLSD_BUS_IDLE;
        end
      end
      rlsd_pkg::RLSD_BUS_RRESP: begin
        if (rready) begin
          next_st.rvalid = 1'b0;
          next_st.bus = rlsd_pkg::RLSD_BUS_IDLE;
        end
      end
      default: begin
        next_st.bus = rlsd_pkg::RLSD_BUS_IDLE;
        next_st.bvalid = 1'b0;
        next_st.rvalid = 1'b0;
      end
    endcase

    next_st.awready = (next_st.bus == rlsd_pkg::RLSD_BUS_IDLE) && !next_st.aw_have;
    next_st.wready = (next_st.bus == rlsd_pkg::RLSD_BUS_IDLE) && !next_st.w_have;
    next_st.arready = (next_st.bus == rlsd_pkg::RLSD_BUS_IDLE)
        && !next_st.aw_have && !next_st.w_have;

    // source selection and division
    case (oscillator_option)
      `RLSD_OSC_LF_A, `RLSD_OSC_LF_B: src_tick = src_edge[0];
      `RLSD_OSC_MF_A, `RLSD_OSC_MF_B: src_tick = src_edge[1];
      `RLSD_OSC_RC: src_tick = src_edge[2];
      `RLSD_OSC_XTAL: src_tick = src_edge[3];
      default: src_tick = 1'b0;
    endcase
    lf_option = oscillator_option inside {`RLSD_OSC_LF_A, `RLSD_OSC_LF_B,
        `RLSD_OSC_MF_A, `RLSD_OSC_MF_B};
    running = !st.disp_ctl[`RLSD_CTL_PANEL_SEL]
        && st.disp_ctl[`RLSD_CTL_DRIVER_ON]
        && (!power_down || lf_option);
    divisor = eff_div(oscillator_option, {st.div_high[0], st.div_low});
    drv_tick = 1'b0;
    if (!running) begin
      next_st.div_cnt = 9'h000;
      next_st.phase = 9'h000;
    end else if (src_tick) begin
      if (st.div_cnt >= divisor - 9'h001) begin
        next_st.div_cnt = 9'h000;
        drv_tick = 1'b1;
      end else begin
        next_st.div_cnt = st.div_cnt + 9'h001;
      end
    end
    if (drv_tick) begin
      next_st.phase = st.phase + 9'h001; // wraps after 512 driver clocks
      next_st.frame_start = (st.phase == 9'(`RLSD_FRAME_TICKS - 1));
    end

    // scan position
    eight_com = st.disp_ctl[`RLSD_CTL_DUTY];
    com_idx = com_of(next_st.phase, eight_com);
    com_pos = eight_com ? {3'h0, next_st.phase[5:0]} : {2'h0, next_st.phase[6:0]};
    charge_len = (eight_com ? `RLSD_COM_PERIOD_8 : `RLSD_COM_PERIOD_4)
        >> (3 + st.drive_ctl[3:2]);
    scheme = st.drive_ctl[1:0];

    // pin functions
    next_st.seg_pin_en = {st.port0_seg[2:0], st.port2_seg, st.port1_seg};
    next_st.com_pin_en = st.port3_com;

    // drive levels
    next_st.display_active = running;
    next_st.quarter_bias = eight_com;
    next_st.bias_sum_900k = st.drive_ctl[`RLSD_DRV_RSUM];
    case (scheme)
      `RLSD_MODE_HIGH_SUM: next_st.low_bias_sel = 1'b0;
      `RLSD_MODE_LOW_SUM: next_st.low_bias_sel = 1'b1;
      `RLSD_MODE_FAST: next_st.low_bias_sel = running && (com_pos < charge_len);
      default: next_st.low_bias_sel = 1'b0;
    endcase
    level = st.disp_ctl[3:0];
    if (!st.disp_ctl[`RLSD_CTL_CONTRAST_EN]) begin
      next_st.panel_supply_level = `RLSD_CONTRAST_FULL;
    end else if (level == `RLSD_CONTRAST_ALIAS) begin
      next_st.panel_supply_level = `RLSD_CONTRAST_FULL;
    end else begin
      next_st.panel_supply_level = level;
    end
    next_st.com_drive = 8'h00;
    next_st.seg_drive = 19'h00000;
    if (running) begin
      next_st.com_drive[com_idx] = 1'b1;
      next_st.com_drive = next_st.com_drive & next_st.com_pin_en;
      for (int s = 0; s < SEG_COUNT; s++) begin
        next_st.seg_drive[s] = st.ram[s][com_idx] && next_st.seg_pin_en[s];
      end
    end

    if (!aresetn) begin
      next_st = '0;
      next_st.bus = rlsd_pkg::RLSD_BUS_IDLE;
      next_st.panel_supply_level = `RLSD_CONTRAST_FULL;
      next_st.disp_ctl = `RLSD_REG_RESET;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign awready = st.awready;
  assign wready = st.wready;
  assign arready = st.arready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign rvalid = st.rvalid;
  assign rresp = st.rresp;
  assign rdata = st.rdata;
  assign com_drive = st.com_drive;
  assign seg_drive = st.seg_drive;
  assign com_pin_en = st.com_pin_en;
  assign seg_pin_en = st.seg_pin_en;
  assign low_bias_sel = st.low_bias_sel;
  assign bias_sum_900k = st.bias_sum_900k;
  assign quarter_bias = st.quarter_bias;
  assign panel_supply_level = st.panel_supply_level;
  assign frame_start = st.frame_start;
  assign display_active = st.display_active;

endmodule : rlsd_driver

/* File: verification/rlsd_props.sv */
/*
 * checker: bus handshake and scan relations at the driver's ports.
 * assumes: bound to rlsd_driver; aresetn synchronous, active low.
 */
`timescale 1ns/10ps
module rlsd_props (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, active low
  input wire logic awvalid, // write address valid
  input wire logic awready, // write address ready
  input wire logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [7:0] com_drive, // common levels
  input wire logic [18:0] seg_drive, // segment levels
  input wire logic [7:0] com_pin_en, // common pins
  input wire logic [18:0] seg_pin_en, // segment pins
  input wire logic frame_start, // frame pulse
  input wire logic display_active // scan running
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------
  // bus
  // --------------------
  sequence seq_wr_taken;
    awvalid && awready && wvalid && wready && !(arvalid && arready);
  endsequence
  sequence seq_rd_taken;
    arvalid && arready;
  endsequence
  chk_wr_answer: assert property (seq_wr_taken |=> bvalid)
    else $error("write not answered next cycle");
  chk_rd_answer: assert property (seq_rd_taken |=> rvalid)
    else $error("read not answered next cycle");
  chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read response dropped early");
  chk_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // --------------------
  // scan
  // --------------------
  chk_reset_blank: assert property (disable iff (1'b0)
    !aresetn |=> com_drive == 8'h00 && seg_drive == 19'h00000 && !display_active)
    else $error("outputs not blank after reset");
  chk_idle_low: assert property (!display_active && !$past(display_active)
    |-> com_drive == 8'h00 && seg_drive == 19'h00000)
    else $error("outputs driven while idle");
  chk_one_common: assert property ($onehot0(com_drive))
    else $error("two commons selected");
  chk_pin_gate: assert property (frame_start |->
    (com_drive & ~com_pin_en) == 8'h00 && (seg_drive & ~seg_pin_en) == 19'h00000)
    else $error("drive on pin not handed over");
  chk_frame_gap: assert property (frame_start |=> !frame_start [*8])
    else $error("frames too close");
  chk_frame_run: assert property (frame_start |-> display_active)
    else $error("frame while not running");
endmodule : rlsd_props

bind rlsd_driver rlsd_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .com_drive(com_drive), .seg_drive(seg_drive),
  .com_pin_en(com_pin_en), .seg_pin_en(seg_pin_en), .frame_start(frame_start),
  .display_active(display_active)
);

/* File: verification/rlsd_glass_model.sv */
/*
 * passive glass panel: latches the segment row seen under each common.
 * assumes: drive levels change on aclk; unhanded pins show nothing.
 */
`timescale 1ns/10ps
module rlsd_glass_model (
  input wire logic aclk, // clock
  input wire logic [7:0] com_drive, // common levels
  input wire logic [18:0] seg_drive, // segment levels
  input wire logic [7:0] com_pin_en, // common pins
  input wire logic [18:0] seg_pin_en, // segment pins
  output logic [7:0][18:0] lit, // last row seen per common
  output int overlap // cycles with two commons on
);
  initial begin
    lit = '0;
    overlap = 0;
  end
  always @(posedge aclk) begin
    if (!$onehot0(com_drive & com_pin_en)) overlap <= overlap + 1;
    for (int c = 0; c < 8; c++) begin
      if (com_drive[c] && com_pin_en[c]) lit[c] <= seg_drive & seg_pin_en;
    end
  end
endmodule : rlsd_glass_model

/* File: verification/tb.sv */
/*
 * testbench: register access over axi4-lite, frame timing, bias and scan.
 * assumes: source clocks slower than aclk/2, made here from aclk.
 */
`timescale 1ns/10ps
`include "rlsd_regs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %0t: got %0h expected %0h", $time, g, e); end end
module tb;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pwr_dn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] opt = 4'ha, psl;
  logic [1:0] src = 2'h0, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, lowb, r900, qb, fst, act;
  logic [7:0] com_drive, com_pin_en;
  logic [18:0] seg_drive, seg_pin_en, e;
  logic [7:0][18:0] lit;
  int overlap, fail_count = 0, tests_run = 0;
  logic [9:0] ridx [8] = '{`RLSD_IDX_PORT1_SEG, `RLSD_IDX_PORT2_SEG, `RLSD_IDX_PORT3_COM,
    `RLSD_IDX_DIV_HIGH, `RLSD_IDX_DISP_CTL, `RLSD_IDX_DIV_LOW, `RLSD_IDX_DRIVE_CTL,
    `RLSD_IDX_PORT0_SEG};
  logic [7:0] rmsk [8] = '{8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hff, 8'h1f, 8'h07};
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) src <= src + 2'h1;
  rlsd_driver dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .oscillator_option(opt), .power_down(pwr_dn), .lf_clk_pin(src[1]),
    .mf_clk_pin(src[1]), .rc_clk_pin(src[1]), .xtal_clk_pin(src[1]),
    .com_drive(com_drive), .seg_drive(seg_drive), .com_pin_en(com_pin_en),
    .seg_pin_en(seg_pin_en), .low_bias_sel(lowb), .bias_sum_900k(r900),
    .quarter_bias(qb), .panel_supply_level(psl), .frame_start(fst), .display_active(act));
  rlsd_glass_model glass (.aclk(aclk), .com_drive(com_drive), .seg_drive(seg_drive),
    .com_pin_en(com_pin_en), .seg_pin_en(seg_pin_en), .lit(lit), .overlap(overlap));
  // --------------------
  // helpers
  // --------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("Error %0t: wait timed out", $time);
      stop_test();
    end
  endtask : tmo
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  function automatic logic [7:0] pat(input int s);
    return 8'(s * 29 + 3);
  endfunction : pat
  task automatic wchk(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    tmo(n, 200);
    `CHK(bresp, er)
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wchk
  task automatic rchk(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    tmo(n, 200);
    `CHK(rdata, ed)
    `CHK(rresp, er)
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rchk
  task automatic frame(input int eper, input int elow);
    int n, per, low;
    n = 0;
    per = 0;
    low = 0;
    while (!fst && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 40000);
    do begin
      @(posedge aclk);
      per++;
      if (lowb) low++;
    end while (!fst && per < 40000);
    tmo(per, 40000);
    `CHK(per, eper)
    `CHK(low, elow)
  endtask : frame
  task automatic regs_zero;
    for (int i = 0; i < 8; i++) rchk(ridx[i], 32'h0, 2'h0);
  endtask : regs_zero
  // --------------------
  // sequence
  // --------------------
  initial begin
    logic [3:0] fo [6] = '{4'ha, 4'hd, 4'h0, 4'he, 4'h3, 4'h6};
    logic [8:0] fd [6] = '{9'h000, 9'h005, 9'h003, 9'h000, 9'h003, 9'h000};
    logic [4:0] fv [6] = '{5'h00, 5'h01, 5'h02, 5'h1e, 5'h06, 5'h0a};
    logic [7:0] cv [5] = '{8'h20, 8'h27, 8'h2e, 8'h2f, 8'h05};
    logic [3:0] ce [5] = '{4'h0, 4'h7, 4'hf, 4'hf, 4'hf};
    int eff, nc, lt;
    cyc(4);
    aresetn <= 1'b1;
    cyc(2);
    regs_zero();
    for (int i = 0; i < 8; i++) begin
      wchk(ridx[i], 8'hff, 2'h0);
      rchk(ridx[i], {24'h0, rmsk[i]}, 2'h0);
    end
    wchk(10'h001, 8'h5a, 2'h2);
    rchk(10'h001, 32'h0, 2'h2);
    for (int s = 0; s < 19; s++) wchk(`RLSD_IDX_RAM_FIRST + 10'(s), pat(s), 2'h0);
    for (int s = 0; s < 19; s++) rchk(`RLSD_IDX_RAM_FIRST + 10'(s), {24'h0, pat(s)}, 2'h0);
    $display("test registers done");
    wchk(`RLSD_IDX_PORT0_SEG, 8'h05, 2'h0);
    wchk(`RLSD_IDX_PORT1_SEG, 8'ha5, 2'h0);
    wchk(`RLSD_IDX_PORT2_SEG, 8'h3c, 2'h0);
    wchk(`RLSD_IDX_PORT3_COM, 8'h96, 2'h0);
    cyc(2);
    `CHK(seg_pin_en, {3'h5, 8'h3c, 8'ha5})
    `CHK(com_pin_en, 8'h96)
    for (int i = 0; i < 4; i++) wchk(ridx[i == 3 ? 7 : i], 8'hff, 2'h0);
    for (int i = 0; i < 5; i++) begin
      wchk(`RLSD_IDX_DISP_CTL, cv[i], 2'h0);
      cyc(2);
      `CHK(psl, ce[i])
    end
    $display("test pins and contrast done");
    for (int i = 0; i < 6; i++) begin
      opt <= fo[i];
      wchk(`RLSD_IDX_DIV_HIGH, {7'h0, fd[i][8]}, 2'h0);
      wchk(`RLSD_IDX_DIV_LOW, fd[i][7:0], 2'h0);
      wchk(`RLSD_IDX_DRIVE_CTL, {3'h0, fv[i]}, 2'h0);
      wchk(`RLSD_IDX_DISP_CTL, {3'b010, i[0], 4'h0}, 2'h0);
      eff = (fo[i] == 4'ha || fo[i] == 4'hd) ? 1 : (fo[i] == 4'h3 || fo[i] == 4'h6) ? 4
        : (fd[i] == 9'h000) ? 1 : int'(fd[i]);
      nc = i[0] ? 8 : 4;
      lt = (fv[i][1:0] == 2'h2) ? nc * ((512 / nc) >> (3 + fv[i][3:2]))
        : (fv[i][1:0] == 2'h1) ? 512 : 0;
      frame(2048 * eff, lt * 4 * eff);
      `CHK(r900, fv[i][4])
      `CHK(qb, i[0])
      `CHK(act, 1'b1)
    end
    for (int c = 0; c < 8; c++) begin
      for (int s = 0; s < 19; s++) e[s] = 1'(pat(s) >> c);
      `CHK(lit[c], e)
    end
    `CHK(overlap, 0)
    $display("test frames done");
    pwr_dn <= 1'b1;
    cyc(4);
    `CHK(act, 1'b1)
    opt <= 4'h0;
    cyc(4);
    `CHK({act, com_drive}, 9'h000)
    rchk(`RLSD_IDX_RAM_FIRST + 10'h005, {24'h0, pat(5)}, 2'h0);
    pwr_dn <= 1'b0;
    opt <= 4'ha;
    wchk(`RLSD_IDX_DISP_CTL, 8'hd0, 2'h0);
    cyc(40);
    `CHK({act, com_drive, seg_drive}, 28'h0)
    wchk(`RLSD_IDX_DISP_CTL, 8'h50, 2'h0);
    cyc(40);
    `CHK(act, 1'b1)
    wchk(`RLSD_IDX_DISP_CTL, 8'h10, 2'h0);
    cyc(40);
    `CHK({act, com_drive, seg_drive}, 28'h0)
    wchk(`RLSD_IDX_DISP_CTL, 8'h50, 2'h0);
    cyc(600);
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(2);
    `CHK({act, com_drive, seg_drive, com_pin_en}, 36'h0)
    regs_zero();
    $display("test power and reset done");
    stop_test();
  end
endmodule : tb
